/* File: shared/cbt_pkg.sv */
// Constants, register map and state type for the CAN bit-timing and filter-steering slice.
// Assumes one 250 MHz module clock and a word-indexed register port.
// Notes on behaviour
// - The transmit error counter reads as bits 15..8 of the error count register, zero at reset.
// - The receive error counter reads as bits 7..0 of the error count register, zero at reset.
// - A resynchronisation moves the bit edge by at most the jump-width code plus one quanta.
// - One time quantum lasts two times (prescaler code plus one) module clock periods.
// - With the wake-up filter bit set, wake-up needs a filtered low bus; otherwise any falling edge.
// - With phase-2 select set, the second phase segment lasts its 3-bit code plus one quanta.
// - With phase-2 select clear, phase 2 is the larger of phase 1 and the processing time.
// - With triple sampling set the bus is majority-voted over three samples, otherwise one.
// - The first phase segment lasts its 3-bit code in bits 5..3 plus one quanta.
// - The propagation segment lasts its 3-bit code in bits 2..0 plus one quanta.
// - Sixteen filter enables, all one at reset; a disabled filter never accepts.
// - A filter hit whose pointer is all ones stores the message into the receive FIFO.
// - A filter hit whose pointer is 0 to 14 stores the message into that receive buffer.
// - Four 4-bit pointers per register, filter 4k in the lowest nibble, all zero at reset.
// - Unused bits of both timing registers read as zero.
// - Bus-off, passive and warning flags are derived from the error counters, read-only.
package cbt_pkg;
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 16;
  localparam logic [3:0]  IDX_ERR_COUNTS  = 4'h0;
  localparam logic [3:0]  IDX_TIMING_A    = 4'h1;
  localparam logic [3:0]  IDX_TIMING_B    = 4'h2;
  localparam logic [3:0]  IDX_FILTER_EN   = 4'h3;
  localparam logic [3:0]  IDX_DEST_0_3    = 4'h4;
  localparam logic [3:0]  IDX_DEST_4_7    = 4'h5;
  localparam logic [3:0]  IDX_DEST_8_11   = 4'h6;
  localparam logic [3:0]  IDX_DEST_12_15  = 4'h7;
  localparam logic [3:0]  IDX_ERR_STATUS  = 4'h8;
  localparam logic [15:0] TIMING_A_MASK   = 16'h00FF;
  localparam logic [15:0] TIMING_B_MASK   = 16'h47FF;
  localparam logic [15:0] TIMING_A_RESET  = 16'h0000;
  localparam logic [15:0] TIMING_B_RESET  = 16'h0000;
  localparam logic [15:0] FILTER_EN_RESET = 16'hFFFF;
  localparam logic [15:0] DEST_RESET      = 16'h0000;
  localparam int          JUMP_LSB        = 6;
  localparam int          PRESCALE_LSB    = 0;
  localparam int          WAKE_SEL_BIT    = 14;
  localparam int          PH2_LEN_LSB     = 8;
  localparam int          PH2_SEL_BIT     = 7;
  localparam int          TRIPLE_SEL_BIT  = 6;
  localparam int          PH1_LEN_LSB     = 3;
  localparam int          PROP_LEN_LSB    = 0;
  localparam logic [3:0]  DEST_FIFO_CODE  = 4'hF;
  localparam logic [3:0]  INFO_PROC_TQ    = 4'h2;
  localparam logic [7:0]  WARN_LEVEL      = 8'h60;
  localparam logic [7:0]  PASSIVE_LEVEL   = 8'h80;
  localparam logic [7:0]  TX_ERR_STEP     = 8'h08;
  localparam int          CLOCK_PERIOD_PS = 4000;
  localparam int          WAKE_FILTER_NS  = 100;
  localparam int          WAKE_FILTER_CYC =
    (WAKE_FILTER_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  typedef enum logic [3:0] {
    ST_SYNC = 4'h1,
    ST_PROP = 4'h2,
    ST_PH1  = 4'h4,
    ST_PH2  = 4'h8
  } cbt_seg_t;
endpackage

/* File: hdl/cbt_top.sv */
// Bit-timing generator, error counters and acceptance-filter steering of a CAN controller.
// Assumes all inputs synchronous to clock; the protocol engine reports error events and hits.
`timescale 1ns/1ps
module cbt_top (
  input  wire logic                      clock,
  input  wire logic                      resetn,
  input  wire logic [cbt_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [cbt_pkg::DATA_W-1:0] regWrData,
  input  wire logic                      regWr,
  input  wire logic                      regRd,
  output logic      [cbt_pkg::DATA_W-1:0] regRdData,
  input  wire logic                      rxLine,
  input  wire logic                      txErrUp,
  input  wire logic                      txErrDown,
  input  wire logic                      rxErrUp,
  input  wire logic                      rxErrDown,
  input  wire logic                      busOffRecover,
  input  wire logic                      filterHit,
  input  wire logic [3:0]                hitFilter,
  output logic                           storeValid,
  output logic                           storeToFifo,
  output logic      [3:0]                storeBuffer,
  output logic                           quantumTick,
  output logic                           bitStart,
  output logic                           samplePoint,
  output logic                           sampledBit,
  output logic                           wakeupDetect,
  output logic                           txBusOff,
  output logic                           txPassive,
  output logic                           rxPassive,
  output logic                           txWarning,
  output logic                           rxWarning
);
  logic [15:0]             timingA;
  logic [15:0]             timingB;
  logic [15:0]             filterEnable;
  logic [15:0]             destReg [4];
  logic [7:0]              txCount;
  logic [7:0]              rxCount;
  logic [6:0]              preCnt;
  logic [3:0]              qCnt;
  cbt_pkg::cbt_seg_t       segState;
  logic [4:0]              extend;
  logic [4:0]              shrink;
  logic                    resyncUsed;
  logic                    rxPrev;
  logic [1:0]              history;
  logic [7:0]              wakeCnt;
  logic [5:0]              prescale;
  logic [4:0]              jumpMax;
  logic [3:0]              ph1Len;
  logic [3:0]              ph2Len;
  logic [3:0]              propLen;
  logic                    fallEdge;
  logic [4:0]              phaseErr;
  logic [4:0]              ph2Left;
  logic [3:0]              hitPointer;
  logic [15:0]             statusWord;
  logic [15:0]             next_rdData;

  assign prescale = timingA[cbt_pkg::PRESCALE_LSB +: 6];
  assign jumpMax  = 5'(timingA[cbt_pkg::JUMP_LSB +: 2]) + 5'h01;
  assign propLen  = 4'(timingB[cbt_pkg::PROP_LEN_LSB +: 3]) + 4'h1;
  assign ph1Len   = 4'(timingB[cbt_pkg::PH1_LEN_LSB +: 3]) + 4'h1;
  always_comb begin
    if (timingB[cbt_pkg::PH2_SEL_BIT]) begin
      ph2Len = 4'(timingB[cbt_pkg::PH2_LEN_LSB +: 3]) + 4'h1;
    end else begin
      ph2Len = (ph1Len > cbt_pkg::INFO_PROC_TQ) ? ph1Len : cbt_pkg::INFO_PROC_TQ;
    end
  end

  // Quantum prescaler: tick every 2*(code+1) clocks
  assign quantumTick = (preCnt == {prescale, 1'b1});
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      preCnt <= 7'h00;
    end else if (quantumTick || (regWr && regAddr == cbt_pkg::IDX_TIMING_A)) begin
      // Restart on a prescaler write, else a shorter code waits out the counter wrap
      preCnt <= 7'h00;
    end else begin
      preCnt <= preCnt + 7'h01;
    end
  end

  assign fallEdge = rxPrev & ~rxLine;
  assign ph2Left  = 5'(ph2Len) - 5'h01 - 5'(qCnt);
  always_comb begin
    phaseErr = 5'h00;
    if (segState == cbt_pkg::ST_PROP) begin
      phaseErr = 5'(qCnt) + 5'h01;
    end else if (segState == cbt_pkg::ST_PH1) begin
      phaseErr = 5'(propLen) + 5'(qCnt) + 5'h01;
    end
  end

  // Segment sequencer; one resynchronisation allowed per bit
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      segState   <= cbt_pkg::ST_SYNC;
      qCnt       <= 4'h0;
      extend     <= 5'h00;
      shrink     <= 5'h00;
      resyncUsed <= 1'b0;
    end else begin
      if (fallEdge && !resyncUsed && segState != cbt_pkg::ST_SYNC) begin
        resyncUsed <= 1'b1;
        if (segState == cbt_pkg::ST_PH2) begin
          shrink <= (ph2Left < jumpMax) ? ph2Left : jumpMax;
        end else begin
          extend <= (phaseErr < jumpMax) ? phaseErr : jumpMax;
        end
      end
      if (quantumTick) begin
        unique case (segState)
          cbt_pkg::ST_SYNC: begin
            segState   <= cbt_pkg::ST_PROP;
            qCnt       <= 4'h0;
            resyncUsed <= 1'b0;
            extend     <= 5'h00;
            shrink     <= 5'h00;
          end
          cbt_pkg::ST_PROP: begin
            if (5'(qCnt) + 5'h01 >= 5'(propLen)) begin
              segState <= cbt_pkg::ST_PH1;
              qCnt     <= 4'h0;
            end else begin
              qCnt <= qCnt + 4'h1;
            end
          end
          cbt_pkg::ST_PH1: begin
            if (5'(qCnt) + 5'h01 >= 5'(ph1Len) + extend) begin
              segState <= cbt_pkg::ST_PH2;
              qCnt     <= 4'h0;
            end else begin
              qCnt <= qCnt + 4'h1;
            end
          end
          cbt_pkg::ST_PH2: begin
            if (5'(qCnt) + 5'h01 + shrink >= 5'(ph2Len)) begin
              segState <= cbt_pkg::ST_SYNC;
              qCnt     <= 4'h0;
            end else begin
              qCnt <= qCnt + 4'h1;
            end
          end
          default: begin
            segState <= cbt_pkg::ST_SYNC;
            qCnt     <= 4'h0;
          end
        endcase
      end
    end
  end

  assign bitStart    = quantumTick && (segState == cbt_pkg::ST_SYNC);
  assign samplePoint = quantumTick && (segState == cbt_pkg::ST_PH1)
                       && (5'(qCnt) + 5'h01 >= 5'(ph1Len) + extend);

  // Samples from the two previous quanta feed the majority vote
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      history    <= 2'b11;
      sampledBit <= 1'b1;
      rxPrev     <= 1'b1;
    end else begin
      rxPrev <= rxLine;
      if (quantumTick) begin
        history <= {history[0], rxLine};
      end
      if (samplePoint) begin
        if (timingB[cbt_pkg::TRIPLE_SEL_BIT]) begin
          sampledBit <= (history[1] & history[0]) | (history[1] & rxLine)
                        | (history[0] & rxLine);
        end else begin
          sampledBit <= rxLine;
        end
      end
    end
  end

  // Filtered wake-up rejects glitches shorter than the filter time
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wakeCnt      <= 8'h00;
      wakeupDetect <= 1'b0;
    end else begin
      wakeCnt <= rxLine ? 8'h00 : ((wakeCnt == 8'hFF) ? wakeCnt : wakeCnt + 8'h01);
      if (timingB[cbt_pkg::WAKE_SEL_BIT]) begin
        wakeupDetect <= (wakeCnt == 8'(cbt_pkg::WAKE_FILTER_CYC - 1)) && !rxLine;
      end else begin
        wakeupDetect <= fallEdge;
      end
    end
  end

  // Error counters saturate; an overflowing transmit step means bus-off
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      txCount  <= 8'h00;
      rxCount  <= 8'h00;
      txBusOff <= 1'b0;
    end else begin
      if (txErrUp) begin
        if (txCount > 8'hFF - cbt_pkg::TX_ERR_STEP) begin
          txCount  <= 8'hFF;
          txBusOff <= 1'b1;
        end else begin
          txCount <= txCount + cbt_pkg::TX_ERR_STEP;
        end
      end else if (busOffRecover) begin
        txCount  <= 8'h00;
        txBusOff <= 1'b0;
      end else if (txErrDown && txCount != 8'h00) begin
        txCount <= txCount - 8'h01;
      end
      if (rxErrUp && rxCount != 8'hFF) begin
        rxCount <= rxCount + 8'h01;
      end else if (busOffRecover && !rxErrUp) begin
        rxCount <= 8'h00;
      end else if (rxErrDown && !rxErrUp && rxCount != 8'h00) begin
        rxCount <= rxCount - 8'h01;
      end
    end
  end

  assign txPassive = (txCount >= cbt_pkg::PASSIVE_LEVEL) && !txBusOff;
  assign rxPassive = (rxCount >= cbt_pkg::PASSIVE_LEVEL);
  assign txWarning = (txCount >= cbt_pkg::WARN_LEVEL);
  assign rxWarning = (rxCount >= cbt_pkg::WARN_LEVEL);
  assign statusWord = {2'b00, txBusOff, txPassive, rxPassive, txWarning, rxWarning,
                       txWarning | rxWarning, 8'h00};

  // Register writes
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      timingA      <= cbt_pkg::TIMING_A_RESET;
      timingB      <= cbt_pkg::TIMING_B_RESET;
      filterEnable <= cbt_pkg::FILTER_EN_RESET;
      for (int i = 0; i < 4; i++) begin
        destReg[i] <= cbt_pkg::DEST_RESET;
      end
    end else if (regWr) begin
      unique case (regAddr)
        cbt_pkg::IDX_TIMING_A:   timingA <= regWrData & cbt_pkg::TIMING_A_MASK;
        cbt_pkg::IDX_TIMING_B:   timingB <= regWrData & cbt_pkg::TIMING_B_MASK;
        cbt_pkg::IDX_FILTER_EN:  filterEnable <= regWrData;
        cbt_pkg::IDX_DEST_0_3:   destReg[0] <= regWrData;
        cbt_pkg::IDX_DEST_4_7:   destReg[1] <= regWrData;
        cbt_pkg::IDX_DEST_8_11:  destReg[2] <= regWrData;
        cbt_pkg::IDX_DEST_12_15: destReg[3] <= regWrData;
        default: begin
        end
      endcase
    end
  end

  // Register reads, data valid in the cycle after the strobe only
  always_comb begin
    next_rdData = 16'h0000;
    unique case (regAddr)
      cbt_pkg::IDX_ERR_COUNTS: next_rdData = {txCount, rxCount};
      cbt_pkg::IDX_TIMING_A:   next_rdData = timingA & cbt_pkg::TIMING_A_MASK;
      cbt_pkg::IDX_TIMING_B:   next_rdData = timingB & cbt_pkg::TIMING_B_MASK;
      cbt_pkg::IDX_FILTER_EN:  next_rdData = filterEnable;
      cbt_pkg::IDX_DEST_0_3:   next_rdData = destReg[0];
      cbt_pkg::IDX_DEST_4_7:   next_rdData = destReg[1];
      cbt_pkg::IDX_DEST_8_11:  next_rdData = destReg[2];
      cbt_pkg::IDX_DEST_12_15: next_rdData = destReg[3];
      cbt_pkg::IDX_ERR_STATUS: next_rdData = statusWord;
      default:                 next_rdData = 16'h0000;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      regRdData <= 16'h0000;
    end else begin
      regRdData <= regRd ? next_rdData : 16'h0000;
    end
  end

  // Destination steering for a reported filter hit
  assign hitPointer = destReg[hitFilter[3:2]][{hitFilter[1:0], 2'b00} +: 4];
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      storeValid  <= 1'b0;
      storeToFifo <= 1'b0;
      storeBuffer <= 4'h0;
    end else begin
      storeValid <= filterHit && filterEnable[hitFilter];
      if (filterHit && filterEnable[hitFilter]) begin
        storeToFifo <= (hitPointer == cbt_pkg::DEST_FIFO_CODE);
        storeBuffer <= hitPointer;
      end
    end
  end

  // Helper: clocks since the previous quantum tick
  logic [7:0] tickGap;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tickGap <= 8'h00;
    end else begin
      tickGap <= (quantumTick || (regWr && regAddr == cbt_pkg::IDX_TIMING_A)) ? 8'h00
                 : tickGap + 8'h01;
    end
  end

  AST_TQ_PERIOD: assert property (@(posedge clock) disable iff (!resetn)
    quantumTick && $stable(timingA) && $past(quantumTick) == 1'b0 && tickGap != 8'h00
    |-> tickGap == 8'(2 * prescale + 1))
    else $error("quantum period does not match prescaler");
  AST_TX_STEP: assert property (@(posedge clock) disable iff (!resetn)
    txErrUp && txCount < 8'hF0 |=> txCount == $past(txCount) + 8'h08)
    else $error("transmit counter did not step by eight");
  AST_RX_STEP: assert property (@(posedge clock) disable iff (!resetn)
    rxErrUp && rxCount < 8'hFF |=> rxCount == $past(rxCount) + 8'h01)
    else $error("receive counter did not step by one");
  AST_DISABLED_DROP: assert property (@(posedge clock) disable iff (!resetn)
    filterHit && !filterEnable[hitFilter] |=> !storeValid)
    else $error("disabled filter accepted a message");
  AST_FIFO_STEER: assert property (@(posedge clock) disable iff (!resetn)
    filterHit && filterEnable[hitFilter] && hitPointer == 4'hF |=> storeValid && storeToFifo)
    else $error("all-ones pointer not steered to FIFO");
  AST_BUF_STEER: assert property (@(posedge clock) disable iff (!resetn)
    filterHit && filterEnable[hitFilter] && hitPointer != 4'hF
    |=> storeValid && !storeToFifo && storeBuffer == $past(hitPointer))
    else $error("buffer pointer not honoured");
  AST_SAMPLE_THEN_PH2: assert property (@(posedge clock) disable iff (!resetn)
    samplePoint |-> segState == cbt_pkg::ST_PH1 ##1 segState == cbt_pkg::ST_PH2)
    else $error("sample point not at end of phase 1");
  AST_SYNC_ONE_TQ: assert property (@(posedge clock) disable iff (!resetn)
    bitStart |=> segState == cbt_pkg::ST_PROP && qCnt == 4'h0)
    else $error("sync segment longer than one quantum");
  AST_WAKE_DIRECT: assert property (@(posedge clock) disable iff (!resetn)
    !timingB[14] && rxPrev && !rxLine |=> wakeupDetect)
    else $error("unfiltered wake-up missed");
  AST_CFG_A_UPPER: assert property (@(posedge clock) disable iff (!resetn)
    regRd && regAddr == 4'h1 |=> regRdData[15:8] == 8'h00)
    else $error("unused timing bits read nonzero");
endmodule // cbt_top

/* File: dv/cbt_bus_node.sv */
// Model of another node on the CAN bus, seen as the receive line.
// Assumes the bench calls pull_dominant by hierarchy; the line idles recessive.
`timescale 1ns/1ps
module cbt_bus_node (
  input  wire logic clock,
  output logic      rxLine
);
  initial rxLine = 1'b1;

  // Dominant for n clocks, then released back to recessive
  task automatic pull_dominant(input int n);
    @(posedge clock);
    rxLine <= 1'b0;
    repeat (n) @(posedge clock);
    rxLine <= 1'b1;
  endtask
endmodule // cbt_bus_node

/* File: dv/tb_top.sv */
// Self-checking bench for the CAN bit-timing and filter-steering slice.
// Assumes the register port answers one cycle after a read strobe.
`timescale 1ns/1ps
module tb_top;
  logic        clock, resetn, regWr, regRd, rxLine;
  logic [3:0]  regAddr, hitFilter, storeBuffer;
  logic [15:0] regWrData, regRdData;
  logic        txErrUp, txErrDown, rxErrUp, rxErrDown, busOffRecover, filterHit;
  logic        storeValid, storeToFifo, quantumTick, bitStart, samplePoint;
  logic        sampledBit, wakeupDetect, txBusOff, txPassive, rxPassive;
  logic        txWarning, rxWarning;
  int          err_total, n_compared, cycles, wakes;

  cbt_top u_dut (.clock(clock), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .rxLine(rxLine),
    .txErrUp(txErrUp), .txErrDown(txErrDown), .rxErrUp(rxErrUp), .rxErrDown(rxErrDown),
    .busOffRecover(busOffRecover), .filterHit(filterHit), .hitFilter(hitFilter),
    .storeValid(storeValid), .storeToFifo(storeToFifo), .storeBuffer(storeBuffer),
    .quantumTick(quantumTick), .bitStart(bitStart), .samplePoint(samplePoint),
    .sampledBit(sampledBit), .wakeupDetect(wakeupDetect), .txBusOff(txBusOff),
    .txPassive(txPassive), .rxPassive(rxPassive), .txWarning(txWarning),
    .rxWarning(rxWarning));
  cbt_bus_node u_node (.clock(clock), .rxLine(rxLine));

  initial clock = 1'b0;
  always #2 clock = ~clock;

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Generous ceiling: the whole sequence needs under two thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_total++;
      close_out();
    end
  end
  always @(negedge clock) if (wakeupDetect === 1'b1) wakes++;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    regWr <= 1'b1; regAddr <= a; regWrData <= d;
    @(posedge clock);
    regWr <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clock);
    regRd <= 1'b1; regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    @(negedge clock);
    chk(regRdData, exp, "register read");
  endtask
  // Pulses {recover, rxDown, rxUp, txDown, txUp} n times
  task automatic evt(input logic [4:0] m, input int n);
    repeat (n) begin
      @(posedge clock);
      {busOffRecover, rxErrDown, rxErrUp, txErrDown, txErrUp} <= m;
      @(posedge clock);
      {busOffRecover, rxErrDown, rxErrUp, txErrDown, txErrUp} <= 5'h00;
    end
    @(negedge clock);
  endtask
  task automatic hit(input logic [3:0] f, input logic [5:0] exp);
    @(posedge clock);
    filterHit <= 1'b1; hitFilter <= f;
    @(posedge clock);
    filterHit <= 1'b0;
    @(negedge clock);
    chk({10'h000, storeValid, storeToFifo, storeBuffer}, {10'h000, exp}, "steering");
  endtask
  function automatic logic tick(input int s);
    return (s == 0) ? quantumTick : (s == 1) ? bitStart : samplePoint;
  endfunction
  // Clocks from a pulse of a to the next pulse of b
  task automatic gap(input int a, input int b, output int n);
    n = 0;
    do @(negedge clock); while (tick(a) !== 1'b1);
    do begin @(negedge clock); n++; end while (tick(b) !== 1'b1 && n < 2000);
  endtask

  initial begin
    int n, p1, p2, pr;
    logic [15:0] c;
    logic [5:0] codes [3];
    logic [15:0] cfgs [3];
    codes = '{6'h00, 6'h03, 6'h3F};
    cfgs = '{16'h0391, 16'h0000, 16'h0018};
    resetn = 1'b0; regWr = 1'b0; regRd = 1'b0; regAddr = 4'h0; regWrData = 16'h0000;
    {busOffRecover, rxErrDown, rxErrUp, txErrDown, txErrUp} = 5'h00;
    filterHit = 1'b0; hitFilter = 4'h0;
    err_total = 0; n_compared = 0; cycles = 0; wakes = 0;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++) rdchk(4'(i), (i == 3) ? 16'hFFFF : 16'h0000);
    rdchk(4'h9, 16'h0000);
    wr(4'h0, 16'h1234);
    rdchk(4'h0, 16'h0000);
    wr(4'h1, 16'hFFFF);
    rdchk(4'h1, 16'h00FF);
    wr(4'h2, 16'hFFFF);
    rdchk(4'h2, 16'h47FF);
    // Pointer of filter n is n, except filter 15 which points at the FIFO
    for (int k = 0; k < 4; k++) begin
      c = {4'(4*k+3), 4'(4*k+2), 4'(4*k+1), 4'(4*k)};
      wr(4'(4+k), c);
      rdchk(4'(4+k), c);
    end
    for (int f = 0; f < 16; f++) hit(4'(f), {1'b1, f == 15, 4'(f)});
    wr(4'h3, 16'hFFDF);
    hit(4'h5, {1'b0, 1'b1, 4'hF});
    hit(4'h4, {1'b1, 1'b0, 4'h4});
    rdchk(4'h3, 16'hFFDF);
    for (int i = 0; i < 3; i++) begin
      wr(4'h1, {8'h00, 2'b11, codes[i]});
      rdchk(4'h1, {8'h00, 2'b11, codes[i]});
      gap(0, 0, n);
      chk(16'(n), 16'(2 * (codes[i] + 1)), "quantum length");
    end
    wr(4'h1, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      wr(4'h2, cfgs[i]);
      pr = cfgs[i][2:0] + 1;
      p1 = cfgs[i][5:3] + 1;
      p2 = cfgs[i][7] ? cfgs[i][10:8] + 1 : (p1 > cbt_pkg::INFO_PROC_TQ) ?
           p1 : int'(cbt_pkg::INFO_PROC_TQ);
      gap(1, 1, n);
      chk(16'(n), 16'(2 * (1 + pr + p1 + p2)), "bit length");
      gap(1, 2, n);
      chk(16'(n), 16'(2 * (pr + p1)), "sample point");
    end
    evt(5'h01, 12);
    evt(5'h04, 3);
    rdchk(4'h0, 16'h6003);
    rdchk(4'h8, 16'h0500);
    evt(5'h01, 4);
    chk({12'h000, txBusOff, txPassive, txWarning, rxPassive}, 16'h0006, "tx flags");
    evt(5'h02, 1);
    evt(5'h08, 1);
    rdchk(4'h0, 16'h7F02);
    evt(5'h10, 1);
    rdchk(4'h0, 16'h0000);
    evt(5'h04, 128);
    chk({14'h0000, rxPassive, rxWarning}, 16'h0003, "rx flags");
    evt(5'h01, 32);
    chk({15'h0000, txBusOff}, 16'h0001, "bus off");
    rdchk(4'h0, 16'hFF80);
    evt(5'h10, 1);
    chk({15'h0000, txBusOff}, 16'h0000, "recovered");
    wr(4'h2, 16'h0000);
    n = wakes;
    u_node.pull_dominant(3);
    repeat (8) @(negedge clock);
    chk(16'(wakes - n), 16'h0001, "raw wake-up");
    wr(4'h2, 16'h4000);
    n = wakes;
    u_node.pull_dominant(cbt_pkg::WAKE_FILTER_CYC - 5);
    repeat (8) @(negedge clock);
    chk(16'(wakes - n), 16'h0000, "short glitch");
    u_node.pull_dominant(cbt_pkg::WAKE_FILTER_CYC + 5);
    repeat (8) @(negedge clock);
    chk(16'(wakes - n), 16'h0001, "filtered wake-up");
    // One-cycle dominant glitch at the sample point: kept by one sample, outvoted by three
    for (int i = 0; i < 2; i++) begin
      wr(4'h2, (i == 0) ? 16'h0000 : 16'h0040);
      do @(negedge clock); while (samplePoint !== 1'b1);
      repeat (9) @(posedge clock);
      u_node.pull_dominant(1);
      @(negedge clock);
      chk({15'h0000, sampledBit}, 16'(i), "sampled bit");
    end
    // Edge in phase 1 with a phase error of five quanta; 18 quanta per bit without it
    for (int j = 0; j < 4; j += 3) begin
      wr(4'h1, {8'h00, 2'(j), 6'h00});
      wr(4'h2, 16'h0038);
      do @(negedge clock); while (bitStart !== 1'b1);
      pr = cycles;
      repeat (8) @(posedge clock);
      u_node.pull_dominant(1);
      do @(negedge clock); while (bitStart !== 1'b1);
      chk(16'(cycles - pr), 16'(2 * (18 + j + 1)), "jump width");
    end
    close_out();
  end
endmodule // tb_top
